// ===== logic/amlr_pkg.sv
// Constants and types for the alert mask and low-bit readout block
// Operation
// - Mask bit 0 blocks low rail alerts
// - Bits 1-3 block core, 3.3V, 5V alerts
// - Bits 4-6 block temperature channel alerts
// - Bit 7 gates second group when fully masked
// - Second bit 0 masks 12V or ID change
// - Second bit 1 read-only, masks overheat pin
// - Second bits 2-4 mask fan failures
// - Second bit 5 masks shared pin event
// - Second bits 6-7 mask diode faults
// - Low-bit register holds four 2-bit fields
// - Low-bit read freezes results until read
// - All three registers reset to zero
package amlr_pkg;
   // Register offsets
   localparam logic [7:0] AMLR_MASK1_ADDR = 8'h74;
   localparam logic [7:0] AMLR_MASK2_ADDR = 8'h75;
   localparam logic [7:0] AMLR_LOWB_ADDR = 8'h76;
   // Upper-byte result registers, one per voltage channel
   localparam logic [7:0] AMLR_MSB_ADDR0 = 8'h20;
   // Reset value and the fully masked value
   localparam logic [7:0] AMLR_REG_RST = 8'h00;
   localparam logic [7:0] AMLR_ALL_ONES = 8'hFF;
   // Field positions
   localparam int AMLR_GATE_BIT = 7;
   localparam int AMLR_OVERHEAT_BIT = 1;
   localparam int AMLR_IDV_BIT = 0;
   localparam int AMLR_SHARED_BIT = 5;
   // Channel count and reading width
   localparam int AMLR_NCH = 4;
   localparam int AMLR_RES = 10;
   // Function of the multiplexed speed-sense pin
   typedef enum logic [1:0] {
      AMLR_P14_SPEED = 2'b00,
      AMLR_P14_OVERHEAT = 2'b01,
      AMLR_P14_ALERT = 2'b10,
      AMLR_P14_GPIO = 2'b11
   } amlr_pin14_t;
endpackage : amlr_pkg

// ===== logic/amlr_lsb_hold.sv
// Per-channel result holding with freeze-until-read
`timescale 1ns/1ps
module amlr_lsb_hold
   import amlr_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic adc_update_i,
   input wire logic [AMLR_NCH*AMLR_RES-1:0] adc_data_i,
   input wire logic freeze_req_i,
   input wire logic [AMLR_NCH-1:0] msb_read_i,
   output logic [AMLR_NCH*AMLR_RES-1:0] held_o,
   output logic frozen_o
);
   // One freeze flag per channel
   logic [AMLR_NCH-1:0] pend_r;
   logic [AMLR_NCH-1:0] pend_nxt;
   logic [AMLR_NCH*AMLR_RES-1:0] held_r;
   logic [AMLR_NCH*AMLR_RES-1:0] held_nxt;

   genvar g;
   generate
      for (g = 0; g < AMLR_NCH; g++) begin : g_ch
         // Next values: a freeze request beats a pending upper-byte read,
         // so a read of both in one cycle still leaves the pair coherent
         always_comb begin
            pend_nxt[g] = pend_r[g];
            held_nxt[g*AMLR_RES +: AMLR_RES] =
               held_r[g*AMLR_RES +: AMLR_RES];
            if (freeze_req_i) begin
               pend_nxt[g] = 1'b1;
            end else if (msb_read_i[g]) begin
               pend_nxt[g] = 1'b0;
            end
            // Fresh result only lands while the channel is live
            if (adc_update_i && !pend_r[g]) begin
               held_nxt[g*AMLR_RES +: AMLR_RES] =
                  adc_data_i[g*AMLR_RES +: AMLR_RES];
            end
         end

         a_hold_frozen: assert property (@(posedge clock_i)
            disable iff (!rst_n_i)
            pend_r[g] |=> $stable(held_r[g*AMLR_RES +: AMLR_RES]))
            else $error("frozen result changed");
      end
   endgenerate

   // Registers only; cleared so reads start at zero
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_r <= '0;
         held_r <= '0;
      end else begin
         pend_r <= pend_nxt;
         held_r <= held_nxt;
      end
   end

   assign held_o = held_r;
   assign frozen_o = |pend_r;
endmodule : amlr_lsb_hold

// ===== logic/amlr_alert_mask.sv
// Alert masking, alert output and low-bit readout registers
`timescale 1ns/1ps
module amlr_alert_mask
   import amlr_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Latched first-group status: bit 0 low rail, 1 core, 2 3.3V,
   // 3 5V, 4 remote one, 5 on-chip, 6 remote two
   input wire logic [6:0] status1_i,
   // Latched second-group events
   input wire logic twelve_volt_limit_i,
   input wire logic id_change_i,
   input wire logic overheat_pin_event_i,
   input wire logic [2:0] fan_fail_i,
   input wire logic fourth_fan_fail_i,
   input wire logic timer_limit_i,
   input wire logic gpio_assert_i,
   input wire logic [1:0] diode_fault_i,
   // Pin configuration
   input wire logic pin21_is_id_i,
   input wire logic [1:0] pin14_func_i,
   // Source of the read-only overheat mask bit
   input wire logic overheat_event_mask_i,
   // Conversion results
   input wire logic adc_update_i,
   input wire logic [AMLR_NCH*AMLR_RES-1:0] adc_data_i,
   output logic frozen_o,
   output logic alert_n_o
);
   // Software-visible registers
   logic [7:0] mask1_r;
   logic [7:0] mask1_nxt;
   logic [7:0] mask2_r;
   logic [7:0] mask2_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic alert_n_r;
   logic alert_n_nxt;
   // Second-group events after pin function selection
   logic [7:0] status2;
   logic [AMLR_NCH*AMLR_RES-1:0] held;
   logic [7:0] low_bits;
   logic [AMLR_NCH-1:0] msb_read;
   logic low_read;
   amlr_pin14_t p14;

   // True when addr hits upper-byte register of channel ch
   function automatic logic msb_hit(input logic [7:0] addr, input int ch);
      msb_hit = (addr == AMLR_MSB_ADDR0 + 8'(ch));
   endfunction : msb_hit

   assign p14 = amlr_pin14_t'(pin14_func_i);

   // Map shared-pin events to the bit that masks them
   always_comb begin
      status2 = AMLR_REG_RST;
      // 12 V limit or ID change by pin 21 function
      status2[AMLR_IDV_BIT] = pin21_is_id_i ? id_change_i
                                            : twelve_volt_limit_i;
      status2[AMLR_OVERHEAT_BIT] = overheat_pin_event_i;
      status2[4:2] = fan_fail_i;
      case (p14)
         AMLR_P14_SPEED: begin
            status2[AMLR_SHARED_BIT] = fourth_fan_fail_i;
         end
         AMLR_P14_OVERHEAT: begin
            status2[AMLR_SHARED_BIT] = timer_limit_i;
         end
         AMLR_P14_GPIO: begin
            status2[AMLR_SHARED_BIT] = gpio_assert_i;
         end
         // Alert-output function raises no event of its own
         default: begin
            status2[AMLR_SHARED_BIT] = 1'b0;
         end
      endcase
      status2[7:6] = diode_fault_i;
   end

   // Read strobes that drive the freeze logic
   always_comb begin
      low_read = reg_rd_i && (reg_addr_i == AMLR_LOWB_ADDR);
      for (int i = 0; i < AMLR_NCH; i++) begin
         msb_read[i] = reg_rd_i && msb_hit(reg_addr_i, i);
      end
   end

   amlr_lsb_hold u_hold (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .adc_update_i(adc_update_i),
      .adc_data_i(adc_data_i),
      .freeze_req_i(low_read),
      .msb_read_i(msb_read),
      .held_o(held),
      .frozen_o(frozen_o)
   );

   // Gather the two low bits of each held reading
   always_comb begin
      for (int i = 0; i < AMLR_NCH; i++) begin
         low_bits[2*i +: 2] = held[i*AMLR_RES +: 2];
      end
   end

   // Next mask values; writes to the read-only low-bit register vanish
   always_comb begin
      mask1_nxt = mask1_r;
      mask2_nxt = mask2_r;
      if (reg_wr_i && reg_addr_i == AMLR_MASK1_ADDR) begin
         mask1_nxt = reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == AMLR_MASK2_ADDR) begin
         mask2_nxt = reg_wdata_i;
      end
      // Overheat mask bit ignores writes and follows its source
      mask2_nxt[AMLR_OVERHEAT_BIT] = overheat_event_mask_i;
   end

   // Read data, captured the cycle after the strobe
   always_comb begin
      rdata_nxt = rdata_r;
      if (reg_rd_i) begin
         rdata_nxt = AMLR_REG_RST; // Unmapped reads return zero
         if (reg_addr_i == AMLR_MASK1_ADDR) begin
            rdata_nxt = mask1_r;
         end else if (reg_addr_i == AMLR_MASK2_ADDR) begin
            rdata_nxt = mask2_r;
         end else if (low_read) begin
            rdata_nxt = low_bits;
         end else begin
            for (int i = 0; i < AMLR_NCH; i++) begin
               if (msb_hit(reg_addr_i, i)) begin
                  rdata_nxt = held[i*AMLR_RES+2 +: 8];
               end
            end
         end
      end
   end

   // Alert: any unmasked source pulls low; a fully masked second
   // group still alerts unless the gate bit is also set
   always_comb begin
      alert_n_nxt = 1'b1;
      if (|(status1_i & ~mask1_r[6:0])) begin
         alert_n_nxt = 1'b0;
      end
      if (|(status2 & ~mask2_r)) begin
         alert_n_nxt = 1'b0;
      end
      if (mask2_r == AMLR_ALL_ONES && |status2 &&
          !mask1_r[AMLR_GATE_BIT]) begin
         alert_n_nxt = 1'b0;
      end
   end

   // State registers; everything clears so no source starts masked
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask1_r <= AMLR_REG_RST;
         mask2_r <= AMLR_REG_RST;
         rdata_r <= AMLR_REG_RST;
         alert_n_r <= 1'b1;
      end else begin
         mask1_r <= mask1_nxt;
         mask2_r <= mask2_nxt;
         rdata_r <= rdata_nxt;
         alert_n_r <= alert_n_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign alert_n_o = alert_n_r;

   a_mask_write: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      reg_wr_i && reg_addr_i == AMLR_MASK1_ADDR
      |=> mask1_r == $past(reg_wdata_i))
      else $error("mask write lost");
   a_overheat_readonly: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      reg_wr_i && reg_addr_i == AMLR_MASK2_ADDR && !overheat_event_mask_i
      |=> !mask2_r[AMLR_OVERHEAT_BIT])
      else $error("overheat mask bit took a write");
   a_core_alert: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      status1_i[1] && !mask1_r[1] |=> !alert_n_o)
      else $error("core alert missing");
   a_temp_masked: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      status1_i == 7'h10 && mask1_r[4] && status2 == 8'h00 |=> alert_n_o)
      else $error("masked temperature alerted");
   a_gate_block: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      mask2_r == AMLR_ALL_ONES && mask1_r[AMLR_GATE_BIT] &&
      (status1_i & ~mask1_r[6:0]) == 7'h00 |=> alert_n_o)
      else $error("gated second group alerted");
   a_gate_pass: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      mask2_r == AMLR_ALL_ONES && !mask1_r[AMLR_GATE_BIT] && |status2
      |=> !alert_n_o)
      else $error("ungated second group silent");
   a_id_alert: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      pin21_is_id_i && id_change_i && !mask2_r[AMLR_IDV_BIT] |=> !alert_n_o)
      else $error("id change alert missing");
   a_fan_masked: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      status2 == 8'h04 && mask2_r[2] && mask2_r != AMLR_ALL_ONES &&
      status1_i == 7'h00 |=> alert_n_o)
      else $error("masked fan alerted");
   a_gpio_alert: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      p14 == AMLR_P14_GPIO && gpio_assert_i && !mask2_r[AMLR_SHARED_BIT]
      |=> !alert_n_o)
      else $error("gpio alert missing");
   a_diode_alert: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      diode_fault_i[1] && !mask2_r[7] |=> !alert_n_o)
      else $error("diode alert missing");
   a_low_readback: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      low_read |=> reg_rdata_o == $past(low_bits) ##1 frozen_o)
      else $error("low-bit readback or freeze wrong");
   a_quiet_high: assert property (@(posedge clock_i)
      disable iff (!rst_n_i)
      status1_i == 7'h00 && status2 == 8'h00 |=> alert_n_o)
      else $error("alert without source");
endmodule : amlr_alert_mask

// ===== dv/amlr_host.sv
// Register host model that drives the block's register port
`timescale 1ns/1ps
module amlr_host
   import amlr_pkg::*;
(
   input wire logic clock_i,
   input wire logic [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] wdata_o
);
   // Idle port at time zero
   initial begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
   end

   // One write strobe; data inverted afterwards so nothing stale lingers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clock_i);
      wr_o = 1'b0;
      wdata_o = ~d;
   endtask : wr

   // One read strobe; registered data is taken one cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clock_i);
      rd_o = 1'b0;
      d = rdata_i;
   endtask : rd

   // Low bits first, then every upper byte to release the hold
   task automatic coherent(output logic [7:0] lo, output logic [31:0] hi);
      logic [7:0] b;
      rd(AMLR_LOWB_ADDR, lo);
      for (int c = 0; c < 4; c++) begin
         rd(AMLR_MSB_ADDR0 + 8'(c), b);
         hi[c*8 +: 8] = b;
      end
   endtask : coherent
endmodule : amlr_host

// ===== dv/amlr_alert_mask_tb.sv
// Self-checking bench for the alert mask and low-bit readout block
`timescale 1ns/1ps
module amlr_alert_mask_tb;
   import amlr_pkg::*;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr, wdata, rdata, got, lo, m1, m2, r;
   logic wr, rd, frozen, alert_n;
   logic upd = 1'b0;
   logic pin21 = 1'b0;
   logic ovm = 1'b0;
   logic [6:0] s1 = 7'h00;
   // Second-group event lines, packed for random fill
   logic [10:0] ev = 11'h000;
   logic [1:0] p14 = 2'b00;
   logic [39:0] adc = 40'h0;
   logic [39:0] res_a;
   logic [31:0] hi;
   // Shift register start value, 88
   logic [7:0] seed = 8'h58;
   logic [7:0] ra[4] = '{AMLR_MASK1_ADDR, AMLR_MASK2_ADDR, AMLR_LOWB_ADDR,
      8'h10};
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   // Reference model kept in integers, built from the rules
   int mdl_m1 = 0;
   int mdl_m2 = 0;
   int mdl_held[4] = '{default: 0};
   bit mdl_frz[4] = '{default: 1'b0};
   // Expected read data in the order the reads are issued
   int exp_q[$];

   always #50 clock_i = ~clock_i;

   // Hang guard, far above the 540 or so cycles the run needs
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end

   amlr_host i_host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
      .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

   amlr_alert_mask i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .status1_i(s1), .twelve_volt_limit_i(ev[0]),
      .id_change_i(ev[1]), .overheat_pin_event_i(ev[2]),
      .fan_fail_i(ev[5:3]), .fourth_fan_fail_i(ev[6]),
      .timer_limit_i(ev[7]), .gpio_assert_i(ev[8]),
      .diode_fault_i(ev[10:9]), .pin21_is_id_i(pin21),
      .pin14_func_i(p14), .overheat_event_mask_i(ovm),
      .adc_update_i(upd), .adc_data_i(adc), .frozen_o(frozen),
      .alert_n_o(alert_n));

   // Eight-bit shift register noise source
   function automatic logic [7:0] rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction : rnd

   // Register read data against the oldest model answer
   task automatic chk_rdata(input string n, input logic [7:0] g);
      logic [7:0] e;
      e = 8'(exp_q.pop_front());
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk_rdata

   // Alert level against the model
   task automatic chk_alert(input logic e);
      samples_checked++;
      if (alert_n !== e) begin
         n_errors++;
         $display("unexpected alert_n: expected %b seen %b", e, alert_n);
      end
   endtask : chk_alert

   // Freeze flag against the model's per-channel flags
   task automatic chk_frozen();
      logic e;
      e = mdl_frz[0] | mdl_frz[1] | mdl_frz[2] | mdl_frz[3];
      samples_checked++;
      if (frozen !== e) begin
         n_errors++;
         $display("unexpected frozen: expected %b seen %b", e, frozen);
      end
   endtask : chk_frozen

   task automatic test_done();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   // Model write: only the masks store, bit 1 of the second never does
   task automatic mdl_wr(input logic [7:0] a, input logic [7:0] d);
      if (a == AMLR_MASK1_ADDR) begin
         mdl_m1 = int'(d);
      end else if (a == AMLR_MASK2_ADDR) begin
         mdl_m2 = int'(d & 8'hFD);
      end
   endtask : mdl_wr

   // Model read: low bits freeze every channel, an upper byte frees one
   task automatic mdl_rd(input logic [7:0] a);
      int v;
      int c;
      v = 0;
      c = int'(a) - int'(AMLR_MSB_ADDR0);
      if (a == AMLR_MASK1_ADDR) begin
         v = mdl_m1;
      end else if (a == AMLR_MASK2_ADDR) begin
         v = mdl_m2 | (ovm ? 2 : 0);
      end else if (a == AMLR_LOWB_ADDR) begin
         for (int k = 0; k < AMLR_NCH; k++) begin
            v = v | ((mdl_held[k] % 4) << (2 * k));
            mdl_frz[k] = 1'b1;
         end
      end else if (c >= 0 && c < AMLR_NCH) begin
         v = mdl_held[c] / 4;
         mdl_frz[c] = 1'b0;
      end
      exp_q.push_back(v);
   endtask : mdl_rd

   // Model result update: a frozen channel keeps its old reading
   task automatic mdl_load(input logic [39:0] d);
      for (int k = 0; k < AMLR_NCH; k++) begin
         if (!mdl_frz[k]) begin
            mdl_held[k] = int'(d[k*AMLR_RES +: AMLR_RES]);
         end
      end
   endtask : mdl_load

   // Model alert level from the masking rules
   function automatic logic mdl_alert_n();
      int m2;
      int g2;
      int sh;
      m2 = mdl_m2 | (ovm ? 2 : 0);
      sh = (p14 == 2'b00) ? ev[6] : (p14 == 2'b01) ? ev[7] :
         (p14 == 2'b11) ? ev[8] : 0;
      g2 = (pin21 ? ev[1] : ev[0]) + 2 * ev[2] + 4 * ev[3] + 8 * ev[4] +
         16 * ev[5] + 32 * sh + 64 * ev[9] + 128 * ev[10];
      mdl_alert_n = 1'b1;
      if ((int'(s1) & ~mdl_m1 & 127) != 0) begin
         mdl_alert_n = 1'b0;
      end
      if ((g2 & ~m2 & 255) != 0) begin
         mdl_alert_n = 1'b0;
      end
      if (m2 == 255 && g2 != 0 && mdl_m1 < 128) begin
         mdl_alert_n = 1'b0;
      end
   endfunction : mdl_alert_n

   // Write through the host and into the model
   task automatic wr_both(input logic [7:0] a, input logic [7:0] d);
      mdl_wr(a, d);
      i_host.wr(a, d);
   endtask : wr_both

   // One converter result pulse, mirrored in the model
   task automatic load(input logic [39:0] d);
      mdl_load(d);
      adc = d;
      upd = 1'b1;
      @(negedge clock_i);
      upd = 1'b0;
   endtask : load

   initial begin
      repeat (5) @(negedge clock_i);
      rst_n_i = 1'b1;
      chk_alert(1'b1);
      chk_frozen();
      // Reset values, plus an unmapped offset that must read zero
      foreach (ra[i]) begin
         mdl_rd(ra[i]);
         i_host.rd(ra[i], got);
         chk_rdata("reset value", got);
      end
      wr_both(AMLR_LOWB_ADDR, 8'hFF);
      mdl_rd(AMLR_LOWB_ADDR);
      i_host.rd(AMLR_LOWB_ADDR, got);
      chk_rdata("low bits write", got);
      // Upper bytes read zero and release the freeze the low reads set
      for (int c = 0; c < AMLR_NCH; c++) begin
         mdl_rd(AMLR_MSB_ADDR0 + 8'(c));
         i_host.rd(AMLR_MSB_ADDR0 + 8'(c), got);
         chk_rdata("upper byte reset", got);
      end
      chk_frozen();
      // Random masks and events; every fourth pass fully masks group two
      for (int i = 0; i < 48; i++) begin
         m1 = (i % 4 == 0) ? (rnd() | 8'h7F) : rnd();
         m2 = (i % 4 == 0) ? 8'hFF : rnd();
         ovm = m2[1];
         wr_both(AMLR_MASK1_ADDR, m1);
         wr_both(AMLR_MASK2_ADDR, m2 ^ 8'h02);
         mdl_rd(AMLR_MASK1_ADDR);
         i_host.rd(AMLR_MASK1_ADDR, got);
         chk_rdata("mask first", got);
         mdl_rd(AMLR_MASK2_ADDR);
         i_host.rd(AMLR_MASK2_ADDR, got);
         chk_rdata("mask second", got);
         s1 = 7'(rnd() & rnd());
         ev = 11'({rnd(), rnd()} & {rnd(), rnd()});
         r = rnd();
         pin21 = r[0];
         p14 = r[2:1];
         repeat (2) @(negedge clock_i);
         chk_alert(mdl_alert_n());
      end
      // Single sources under their own mask, then one unmasked again
      ovm = 1'b0;
      s1 = 7'h00;
      ev = 11'h000;
      wr_both(AMLR_MASK1_ADDR, 8'h10);
      wr_both(AMLR_MASK2_ADDR, 8'h04);
      s1 = 7'h10;
      repeat (2) @(negedge clock_i);
      chk_alert(mdl_alert_n());
      s1 = 7'h00;
      ev = 11'h008;
      repeat (2) @(negedge clock_i);
      chk_alert(mdl_alert_n());
      wr_both(AMLR_MASK2_ADDR, 8'h00);
      repeat (2) @(negedge clock_i);
      chk_alert(mdl_alert_n());
      ev = 11'h000;
      // Freeze: a later result must not reach the held registers
      res_a = {rnd(), rnd(), rnd(), rnd(), rnd()};
      load(res_a);
      mdl_rd(AMLR_LOWB_ADDR);
      i_host.rd(AMLR_LOWB_ADDR, got);
      chk_rdata("low bits", got);
      chk_frozen();
      load(~res_a);
      mdl_rd(AMLR_LOWB_ADDR);
      for (int c = 0; c < AMLR_NCH; c++) begin
         mdl_rd(AMLR_MSB_ADDR0 + 8'(c));
      end
      i_host.coherent(lo, hi);
      chk_rdata("low bits frozen", lo);
      for (int c = 0; c < AMLR_NCH; c++) begin
         chk_rdata("upper byte", hi[c*8 +: 8]);
      end
      @(negedge clock_i);
      chk_frozen();
      load(~res_a);
      mdl_rd(AMLR_LOWB_ADDR);
      i_host.rd(AMLR_LOWB_ADDR, got);
      chk_rdata("low bits live", got);
      test_done();
   end
endmodule : amlr_alert_mask_tb
